/* File: rtl/oms_consts.svh */
`ifndef OMS_CONSTS_SVH
`define OMS_CONSTS_SVH

// Width of a speed command word.
`define OMS_SPEED_W 16

// Register offsets on the plain register port.
`define OMS_ADDR_MODE_SEL 4'h0
`define OMS_ADDR_STATUS 4'h1
`define OMS_ADDR_HOST_CMD 4'h2
`define OMS_ADDR_LINK_SPD_LO 4'h3
`define OMS_ADDR_LINK_SPD_HI 4'h4
`define OMS_ADDR_LINK_DIR 4'h5

// Mode selection parameter values; 5 and above 8 are invalid.
`define OMS_MSEL_TOGGLE 4'h0
`define OMS_MSEL_PANEL 4'h1
`define OMS_MSEL_EXT 4'h2
`define OMS_MSEL_COMB1 4'h3
`define OMS_MSEL_COMB2 4'h4
`define OMS_MSEL_HOLE 4'h5
`define OMS_MSEL_SWITCH 4'h6
`define OMS_MSEL_ILOCK 4'h7
`define OMS_MSEL_EXTSW 4'h8
`define OMS_MSEL_RESET 4'h0

// Host command codes written to the host command register.
`define OMS_HCMD_TO_LINK 8'h01
`define OMS_HCMD_TO_EXT 8'h02

// Status register field positions.
`define OMS_STAT_MODE_LSB 0
`define OMS_STAT_STOP_BIT 2
`define OMS_STAT_OSTOP_BIT 3

`endif

/* File: rtl/oms_pkg.sv */
`include "oms_consts.svh"

package oms_pkg;

  // Operating mode actually in force.
  typedef enum logic [1:0] {
    OMS_OP_EXT = 2'b00,
    OMS_OP_PANEL = 2'b01,
    OMS_OP_LINK = 2'b10
  } oms_opmode_type;

  // Rotation request: forward and reverse.
  typedef struct packed {
    logic panel_forward_key;
    logic panel_reverse_key;
  } oms_run_type;

  // Speed command together with its direction.
  typedef struct packed {
    logic [`OMS_SPEED_W-1:0] speed;
    oms_run_type run;
  } oms_cmd_type;

endpackage

/* File: rtl/oms_param_reg.sv */
`timescale 1ns/10ps
`default_nettype none
`include "oms_consts.svh"

// Holds the mode selection parameter and refuses invalid values.
module oms_param_reg import oms_pkg::*; (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Write request.
  input wire logic i_wr,
  input wire logic [3:0] i_value,
  // Stored value.
  output logic [3:0] o_value
);

  logic valid; // High when the offered value is a legal setting.

  // A value is legal when it is 0 to 8 but not 5.
  always_comb begin
    valid = (i_value <= `OMS_MSEL_EXTSW) && (i_value != `OMS_MSEL_HOLE);
  end

  // The parameter starts at its default and only takes legal writes.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_value <= `OMS_MSEL_RESET;
    end else if (i_wr && valid) begin
      o_value <= i_value;
    end
  end

  property p_reject_bad;
    @(posedge i_core_clk) disable iff (i_rst)
    (i_wr && !valid) |=> $stable(o_value);
  endproperty
  a_reject_bad: assert property (p_reject_bad) else $error("Invalid mode value stored.");

endmodule
`default_nettype wire

/* File: rtl/oms_setpoint.sv */
`timescale 1ns/10ps
`default_nettype none
`include "oms_consts.svh"

// Volatile speed and direction setting for one command source.
module oms_setpoint import oms_pkg::*; (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Carry-over load on a mode change.
  input wire logic i_load,
  input wire oms_cmd_type i_load_cmd,
  // Operator or host updates.
  input wire logic i_speed_wr,
  input wire logic [`OMS_SPEED_W-1:0] i_speed,
  input wire logic i_dir_wr,
  input wire oms_run_type i_dir,
  // Current setting.
  output oms_cmd_type o_cmd
);

  // Reset wipes the setting; a carry-over load beats a same-cycle update.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cmd <= '0;
    end else if (i_load) begin
      o_cmd <= i_load_cmd;
    end else begin
      if (i_speed_wr) begin
        o_cmd.speed <= i_speed;
      end
      if (i_dir_wr) begin
        o_cmd.run <= i_dir;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/oms_mode_selector.sv */
// Summary of operation
// - Power-up with default setting selects external mode.
// - Setting 0: panel key toggles panel/external.
// - Setting 1: panel speed, panel forward/reverse keys.
// - Setting 2: external speed and start terminals.
// - Setting 3: panel or preset speed, external start.
// - Setting 4: external speed, panel start keys.
// - Setting 6: switch panel/external/link while running.
// - Setting 7: interlock on permits panel, stops external.
// - Setting 8: switch input picks mode when stopped.
// - Panel stop works outside panel mode.
// - External to panel keeps direction and speed.
// - Host enters link mode; external values kept.
// - External key in panel mode selects external.
// - Panel to link keeps panel direction, speed.
// - Host command to external uses external inputs.
// - Link to panel keeps link direction, speed.
// - Interlock off forces external mode.
// - Interlock on: start active blocks panel.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "oms_consts.svh"

module oms_mode_selector import oms_pkg::*; (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port.
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Operator panel keys and digital setting.
  input wire logic i_panel_mode_toggle_key,
  input wire logic i_panel_forward_key,
  input wire logic i_panel_reverse_key,
  input wire logic i_panel_stop_key,
  input wire logic i_panel_speed_wr,
  input wire logic [`OMS_SPEED_W-1:0] i_panel_speed,
  // External terminals.
  input wire logic i_forward_start_input,
  input wire logic i_reverse_start_input,
  input wire logic [`OMS_SPEED_W-1:0] i_ext_analog_speed,
  input wire logic i_ext_preset_sel,
  input wire logic [`OMS_SPEED_W-1:0] i_ext_preset_speed,
  input wire logic i_panel_interlock_input,
  input wire logic i_mode_switch_input,
  // Drive status.
  input wire logic i_motor_running,
  // Resulting command.
  output oms_opmode_type o_op_mode,
  output logic [`OMS_SPEED_W-1:0] o_speed_cmd,
  output logic o_run_fwd,
  output logic o_run_rev,
  output logic o_output_stop
);

  logic [3:0] mode_sel; // Stored mode selection parameter.
  oms_opmode_type op_mode; // Operating mode in force.
  oms_opmode_type next_op_mode; // Operating mode for the next cycle.
  oms_cmd_type panel_sp; // Panel speed and direction setting.
  oms_cmd_type link_sp; // Link speed and direction setting.
  oms_cmd_type ext_cmd; // Command formed from the external terminals.
  oms_cmd_type carry_cmd; // Values carried into a newly entered mode.
  oms_cmd_type next_cmd; // Command selected for the output stage.
  oms_run_type panel_dir; // Direction requested by the panel keys.
  logic stop_latch; // Panel stop pressed outside panel mode.
  logic ilock_stop; // External output held off by the interlock.
  logic host_to_link; // Host asked for computer-link mode.
  logic host_to_ext; // Host asked for external mode.
  logic start_any; // Either external start terminal is on.
  logic panel_load; // Panel mode is being entered.
  logic link_load; // Link mode is being entered.
  logic mode_wr; // Write to the mode parameter.

  // Decode register writes into strobes.
  always_comb begin
    mode_wr = i_wr && (i_addr == `OMS_ADDR_MODE_SEL);
    host_to_link = i_wr && (i_addr == `OMS_ADDR_HOST_CMD) && (i_wdata == `OMS_HCMD_TO_LINK);
    host_to_ext = i_wr && (i_addr == `OMS_ADDR_HOST_CMD) && (i_wdata == `OMS_HCMD_TO_EXT);
  end

  // Mode parameter storage with value checking.
  oms_param_reg u_param (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_wr(mode_wr),
    .i_value(i_wdata[3:0]),
    .o_value(mode_sel)
  );

  // External command: preset speed when selected, else the analog input.
  always_comb begin
    start_any = i_forward_start_input || i_reverse_start_input;
    ext_cmd.speed = i_ext_preset_sel ? i_ext_preset_speed : i_ext_analog_speed;
    ext_cmd.run.panel_forward_key = i_forward_start_input && !i_reverse_start_input;
    ext_cmd.run.panel_reverse_key = i_reverse_start_input && !i_forward_start_input;
  end

  // Panel keys: forward or reverse starts, stop clears the request.
  always_comb begin
    panel_dir.panel_forward_key = i_panel_forward_key;
    panel_dir.panel_reverse_key = i_panel_reverse_key && !i_panel_forward_key;
  end

  // Mode transitions for each parameter setting.
  always_comb begin
    next_op_mode = op_mode;
    unique case (mode_sel)
      `OMS_MSEL_TOGGLE: begin
        // Toggle only while the motor is stopped.
        if (i_panel_mode_toggle_key && !i_motor_running) begin
          next_op_mode = (op_mode == OMS_OP_PANEL) ? OMS_OP_EXT : OMS_OP_PANEL;
        end
      end
      `OMS_MSEL_PANEL: next_op_mode = OMS_OP_PANEL;
      `OMS_MSEL_EXT, `OMS_MSEL_COMB1, `OMS_MSEL_COMB2: next_op_mode = OMS_OP_EXT;
      `OMS_MSEL_SWITCH: begin
        // Switching is allowed while running; panel key has priority.
        if (i_panel_mode_toggle_key) begin
          if (op_mode == OMS_OP_PANEL) begin
            next_op_mode = OMS_OP_EXT;
          end else begin
            next_op_mode = OMS_OP_PANEL;
          end
        end else if (host_to_link) begin
          next_op_mode = OMS_OP_LINK;
        end else if (host_to_ext) begin
          next_op_mode = OMS_OP_EXT;
        end
      end
      `OMS_MSEL_ILOCK: begin
        if (!i_panel_interlock_input) begin
          next_op_mode = OMS_OP_EXT;
        end else if (i_panel_mode_toggle_key) begin
          if (op_mode == OMS_OP_PANEL) begin
            next_op_mode = OMS_OP_EXT;
          end else if (!start_any) begin
            next_op_mode = OMS_OP_PANEL;
          end
        end
      end
      `OMS_MSEL_EXTSW: begin
        // The switch input is obeyed only at standstill.
        if (!i_motor_running) begin
          next_op_mode = i_mode_switch_input ? OMS_OP_EXT : OMS_OP_PANEL;
        end
      end
      default: begin
        next_op_mode = OMS_OP_EXT;
      end
    endcase
  end

  // Operating mode register; external mode after reset.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      op_mode <= OMS_OP_EXT;
    end else begin
      op_mode <= next_op_mode;
    end
  end

  // Values carried into the mode being entered.
  always_comb begin
    panel_load = (next_op_mode == OMS_OP_PANEL) && (op_mode != OMS_OP_PANEL);
    link_load = (next_op_mode == OMS_OP_LINK) && (op_mode != OMS_OP_LINK);
    if (op_mode == OMS_OP_LINK) begin
      carry_cmd = link_sp;
    end else if (op_mode == OMS_OP_PANEL) begin
      carry_cmd = panel_sp;
    end else begin
      carry_cmd = ext_cmd;
    end
  end

  // Panel setting: digital speed and the forward, reverse and stop keys.
  oms_setpoint u_panel_sp (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_load(panel_load),
    .i_load_cmd(carry_cmd),
    .i_speed_wr(i_panel_speed_wr),
    .i_speed(i_panel_speed),
    .i_dir_wr(i_panel_forward_key || i_panel_reverse_key || i_panel_stop_key),
    .i_dir(i_panel_stop_key ? oms_run_type'(2'b00) : panel_dir),
    .o_cmd(panel_sp)
  );

  // Link setting: written by the host one speed byte at a time.
  oms_setpoint u_link_sp (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_load(link_load),
    .i_load_cmd(carry_cmd),
    .i_speed_wr(i_wr && ((i_addr == `OMS_ADDR_LINK_SPD_LO) || (i_addr == `OMS_ADDR_LINK_SPD_HI))),
    .i_speed((i_addr == `OMS_ADDR_LINK_SPD_HI) ? {i_wdata, link_sp.speed[7:0]} :
      {link_sp.speed[`OMS_SPEED_W-1:8], i_wdata}),
    .i_dir_wr(i_wr && (i_addr == `OMS_ADDR_LINK_DIR)),
    .i_dir(oms_run_type'(i_wdata[1:0])),
    .o_cmd(link_sp)
  );

  // Panel stop outside panel mode latches until all starts drop.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      stop_latch <= 1'b0;
    end else if (i_panel_stop_key && (op_mode != OMS_OP_PANEL)) begin
      stop_latch <= 1'b1;
    end else if (!start_any && (link_sp.run == 2'b00)) begin
      stop_latch <= 1'b0;
    end
  end

  // Source selection by parameter setting and operating mode.
  always_comb begin
    ilock_stop = (mode_sel == `OMS_MSEL_ILOCK) && (op_mode == OMS_OP_EXT) &&
      i_panel_interlock_input;
    unique case (mode_sel)
      `OMS_MSEL_PANEL: begin
        next_cmd = panel_sp;
      end
      `OMS_MSEL_EXT: begin
        next_cmd = ext_cmd;
      end
      `OMS_MSEL_COMB1: begin
        next_cmd.speed = i_ext_preset_sel ? i_ext_preset_speed : panel_sp.speed;
        next_cmd.run = ext_cmd.run;
      end
      `OMS_MSEL_COMB2: begin
        next_cmd.speed = ext_cmd.speed;
        next_cmd.run = panel_sp.run;
      end
      default: begin
        if (op_mode == OMS_OP_PANEL) begin
          next_cmd = panel_sp;
        end else if (op_mode == OMS_OP_LINK) begin
          next_cmd = link_sp;
        end else begin
          next_cmd = ext_cmd;
        end
      end
    endcase
    if ((stop_latch && (op_mode != OMS_OP_PANEL)) || ilock_stop) begin
      next_cmd.run = 2'b00;
    end
  end

  // Registered outputs toward the drive.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_op_mode <= OMS_OP_EXT;
      o_speed_cmd <= '0;
      o_run_fwd <= 1'b0;
      o_run_rev <= 1'b0;
      o_output_stop <= 1'b0;
    end else begin
      o_op_mode <= next_op_mode;
      o_speed_cmd <= next_cmd.speed;
      o_run_fwd <= next_cmd.run.panel_forward_key;
      o_run_rev <= next_cmd.run.panel_reverse_key;
      o_output_stop <= ilock_stop || (stop_latch && (op_mode != OMS_OP_PANEL));
    end
  end

  // Read data, loaded at the edge that takes the read strobe and held until the next read.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= 8'h00;
      case (i_addr)
        `OMS_ADDR_MODE_SEL: o_rdata <= {4'h0, mode_sel};
        `OMS_ADDR_STATUS: begin
          o_rdata[`OMS_STAT_MODE_LSB +: 2] <= op_mode;
          o_rdata[`OMS_STAT_STOP_BIT] <= stop_latch;
          o_rdata[`OMS_STAT_OSTOP_BIT] <= ilock_stop;
        end
        `OMS_ADDR_LINK_SPD_LO: o_rdata <= link_sp.speed[7:0];
        `OMS_ADDR_LINK_SPD_HI: o_rdata <= link_sp.speed[`OMS_SPEED_W-1:8];
        `OMS_ADDR_LINK_DIR: o_rdata <= {6'h00, link_sp.run};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // A mode change from external to panel in switchover mode.
  sequence s_ext_to_panel;
    (mode_sel == `OMS_MSEL_SWITCH) && (op_mode == OMS_OP_EXT) && i_panel_mode_toggle_key;
  endsequence

  property p_boot_ext;
    $past(i_rst) |-> (op_mode == OMS_OP_EXT) && (o_op_mode == OMS_OP_EXT);
  endproperty
  a_boot_ext: assert property (p_boot_ext) else $error("Not external after reset.");

  property p_toggle;
    ((mode_sel == `OMS_MSEL_TOGGLE) && i_panel_mode_toggle_key && !i_motor_running &&
      (op_mode == OMS_OP_EXT)) |=> (op_mode == OMS_OP_PANEL);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Toggle key ignored.");

  property p_panel_speed;
    (mode_sel == `OMS_MSEL_PANEL) |=> (o_speed_cmd == $past(panel_sp.speed));
  endproperty
  a_panel_speed: assert property (p_panel_speed) else $error("Panel speed not used.");

  property p_ext_speed;
    (mode_sel == `OMS_MSEL_EXT) |=> (o_speed_cmd == $past(ext_cmd.speed));
  endproperty
  a_ext_speed: assert property (p_ext_speed) else $error("External speed not used.");

  property p_comb1;
    ((mode_sel == `OMS_MSEL_COMB1) && !i_ext_preset_sel) |=>
      (o_speed_cmd == $past(panel_sp.speed));
  endproperty
  a_comb1: assert property (p_comb1) else $error("Combined mode 1 speed wrong.");

  property p_comb2;
    ((mode_sel == `OMS_MSEL_COMB2) && !ilock_stop && !stop_latch) |=>
      (o_run_fwd == $past(panel_sp.run.panel_forward_key));
  endproperty
  a_comb2: assert property (p_comb2) else $error("Combined mode 2 start wrong.");

  property p_link_enter;
    ((mode_sel == `OMS_MSEL_SWITCH) && host_to_link && !i_panel_mode_toggle_key) |=>
      (op_mode == OMS_OP_LINK);
  endproperty
  a_link_enter: assert property (p_link_enter) else $error("Link command ignored.");

  property p_ilock_stop;
    ((mode_sel == `OMS_MSEL_ILOCK) && i_panel_interlock_input && (op_mode == OMS_OP_EXT)) |=>
      o_output_stop && !o_run_fwd && !o_run_rev;
  endproperty
  a_ilock_stop: assert property (p_ilock_stop) else $error("Interlock stop missing.");

  property p_extsw_hold;
    ((mode_sel == `OMS_MSEL_EXTSW) && i_motor_running) |=> $stable(op_mode);
  endproperty
  a_extsw_hold: assert property (p_extsw_hold) else $error("Switched while running.");

  property p_carry;
    s_ext_to_panel |=> (panel_sp == $past(ext_cmd));
  endproperty
  a_carry: assert property (p_carry) else $error("Carry-over lost.");

  property p_ilock_off;
    ((mode_sel == `OMS_MSEL_ILOCK) && !i_panel_interlock_input) |=> (op_mode == OMS_OP_EXT);
  endproperty
  a_ilock_off: assert property (p_ilock_off) else $error("Interlock off not forced.");

  property p_ilock_start;
    ((mode_sel == `OMS_MSEL_ILOCK) && (op_mode == OMS_OP_EXT) && start_any) |=>
      (op_mode != OMS_OP_PANEL);
  endproperty
  a_ilock_start: assert property (p_ilock_start) else $error("Panel entered with start on.");

endmodule
`default_nettype wire

/* File: tb/oms_far_side.sv */
`timescale 1ns/10ps
`default_nettype none

// Host computer receive side: it remembers each read strobe and takes the word that
// the drive returns in the cycle after the strobe.
module oms_far_side import oms_pkg::*; (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port as the host sees it.
  input wire logic i_rd,
  input wire logic [7:0] i_rdata,
  // Word taken and its one-cycle marker.
  output logic [7:0] o_word,
  output logic o_word_valid
);
  logic rd_seen; // A read strobe was taken at the last edge.

  // The answer comes one cycle after the strobe, so the strobe is remembered.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rd_seen <= 1'b0;
    end else begin
      rd_seen <= i_rd;
    end
  end

  // The word is taken at the edge that closes its cycle and marked for one cycle.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_word <= 8'h00;
      o_word_valid <= 1'b0;
    end else begin
      o_word_valid <= rd_seen;
      if (rd_seen) begin
        o_word <= i_rdata;
      end
    end
  end
endmodule

`default_nettype wire

/* File: tb/oms_mode_selector_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "oms_consts.svh"

// Self-checking bench for the operation mode selector.
module oms_mode_selector_bench import oms_pkg::*;;
  logic core_clk, panel_forward_key, panel_reverse_key, ostop, word_valid;
  logic rst = 1'b1;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic pspd_wr = 1'b0;
  logic psel = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] keys = 4'h0;
  logic [4:0] lv = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, word;
  logic [15:0] pspd = 16'h0000;
  logic [15:0] analog = 16'h0000;
  logic [15:0] preset = 16'h0000;
  logic [15:0] spd;
  oms_opmode_type mode;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h43;

  // Free running clock at 4 ns.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  oms_mode_selector oms_mode_selector_inst (
    .i_core_clk(core_clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(rdata),
    .i_panel_mode_toggle_key(keys[0]), .i_panel_forward_key(keys[1]),
    .i_panel_reverse_key(keys[2]), .i_panel_stop_key(keys[3]),
    .i_panel_speed_wr(pspd_wr), .i_panel_speed(pspd),
    .i_forward_start_input(lv[4]), .i_reverse_start_input(lv[3]),
    .i_ext_analog_speed(analog), .i_ext_preset_sel(psel),
    .i_ext_preset_speed(preset), .i_panel_interlock_input(lv[2]),
    .i_mode_switch_input(lv[1]), .i_motor_running(lv[0]),
    .o_op_mode(mode), .o_speed_cmd(spd), .o_run_fwd(panel_forward_key), .o_run_rev(panel_reverse_key),
    .o_output_stop(ostop));

  // Host receive side: takes read data only in the cycle after the read strobe.
  oms_far_side far (
    .i_core_clk(core_clk), .i_rst(rst), .i_rd(rd_stb), .i_rdata(rdata),
    .o_word(word), .o_word_valid(word_valid));

  // Host write: one strobe cycle; released data lines flip so stale data cannot pass.
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    wdata <= ~d;
  endtask

  // Host read: the word that the host model took after the strobe is handed over.
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    @(posedge core_clk);
    #1;
    d = word_valid ? word : 8'hxx;
  endtask

  // One press of a panel key lasts one cycle.
  task automatic key(input int k);
    @(posedge core_clk);
    keys[k] <= 1'b1;
    @(posedge core_clk);
    keys[k] <= 1'b0;
  endtask

  // Panel digital speed entry.
  task automatic pset(input logic [15:0] v);
    @(posedge core_clk);
    pspd_wr <= 1'b1;
    pspd <= v;
    @(posedge core_clk);
    pspd_wr <= 1'b0;
    pspd <= ~v;
  endtask

  // Terminal and drive status levels.
  task automatic set_lv(input logic [4:0] v);
    @(posedge core_clk);
    lv <= v;
  endtask

  // External speed sources and the preset select.
  task automatic set_sp(input logic [15:0] a, input logic p, input logic [15:0] q);
    @(posedge core_clk);
    analog <= a;
    psel <= p;
    preset <= q;
  endtask

  // Fixed-seed xorshift source for speeds.
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  // Compares one value and counts the outcome.
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  // Model outputs after the two-cycle settle; a negative field is not compared.
  task automatic out(input int md, input int s, input int f, input int r);
    repeat (2) @(posedge core_clk);
    #1;
    if (md >= 0) chk({14'h0, mode}, 16'(md));
    if (s >= 0) chk(spd, 16'(s));
    if (f >= 0) chk({15'h0, panel_forward_key}, 16'(f));
    if (r >= 0) chk({15'h0, panel_reverse_key}, 16'(r));
  endtask

  // Synchronous reset held for four cycles.
  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  // Single place where the run ends.
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch.
  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    conclude();
  end

  initial begin
    logic [7:0] d;
    logic [15:0] a, b, c;
    int mp;
    int q[$];
    do_reset();
    out(0, 0, 0, 0);
    bus_rd(4'h0, d);
    chk({8'h0, d}, 16'h0);
    bus_rd(4'h9, d);
    chk({8'h0, d}, 16'h0);
    // Every code, invalid ones must leave the stored value alone.
    mp = 0;
    for (int v = 15; v >= 0; v--) begin
      bus_wr(4'h0, 8'(v));
      if (v != 5 && v <= 8) mp = v;
      q.push_back(mp);
      bus_rd(4'h0, d);
      chk({8'h0, d}, 16'(q.pop_front()));
    end
    // External operation only.
    do_reset();
    bus_wr(4'h0, 8'h02);
    a = rnd();
    b = rnd();
    set_sp(a, 1'b0, b);
    set_lv(5'b10000);
    out(0, a, 1, 0);
    set_sp(a, 1'b1, b);
    out(0, b, 1, 0);
    set_lv(5'b11000);
    out(0, b, 0, 0);
    set_lv(5'b01000);
    out(0, b, 0, 1);
    key(3);
    bus_rd(4'h1, d);
    chk({8'h0, d & 8'h07}, 16'h4);
    // Panel operation only.
    do_reset();
    bus_wr(4'h0, 8'h01);
    c = rnd();
    pset(c);
    key(1);
    out(1, c, 1, 0);
    key(2);
    out(1, c, 0, 1);
    // Combined modes.
    do_reset();
    bus_wr(4'h0, 8'h03);
    set_sp(a, 1'b0, b);
    pset(c);
    set_lv(5'b10000);
    out(-1, c, 1, 0);
    set_sp(a, 1'b1, b);
    out(-1, b, 1, 0);
    do_reset();
    bus_wr(4'h0, 8'h04);
    set_sp(a, 1'b0, b);
    set_lv(5'b00000);
    key(1);
    out(-1, a, 1, 0);
    // Toggle key mode, refused while running.
    do_reset();
    key(0);
    out(1, -1, -1, -1);
    key(0);
    out(0, -1, -1, -1);
    set_lv(5'b00001);
    key(0);
    out(0, -1, -1, -1);
    // Mode switch input.
    do_reset();
    set_lv(5'b00010);
    bus_wr(4'h0, 8'h08);
    out(0, -1, -1, -1);
    set_lv(5'b00000);
    out(1, -1, -1, -1);
    set_lv(5'b00011);
    out(1, -1, -1, -1);
    set_lv(5'b00010);
    out(0, -1, -1, -1);
    // Panel interlock.
    do_reset();
    set_sp(a, 1'b0, b);
    set_lv(5'b10000);
    bus_wr(4'h0, 8'h07);
    out(0, a, 1, 0);
    set_lv(5'b10100);
    out(0, -1, 0, 0);
    chk({15'h0, ostop}, 16'h1);
    key(0);
    out(0, -1, -1, -1);
    set_lv(5'b00100);
    key(0);
    out(1, -1, -1, -1);
    set_lv(5'b10000);
    out(0, a, 1, 0);
    key(0);
    out(0, -1, -1, -1);
    // Switchover mode while running.
    do_reset();
    a = rnd();
    set_sp(a, 1'b0, b);
    set_lv(5'b10001);
    bus_wr(4'h0, 8'h06);
    out(0, a, 1, 0);
    key(0);
    out(1, a, 1, 0);
    a = rnd();
    set_sp(a, 1'b0, b);
    set_lv(5'b01001);
    key(0);
    out(0, a, 0, 1);
    bus_wr(4'h2, `OMS_HCMD_TO_LINK);
    out(2, a, 0, 1);
    c = rnd();
    bus_wr(4'h3, c[7:0]);
    bus_wr(4'h4, c[15:8]);
    bus_wr(4'h5, 8'h02);
    out(2, c, 1, 0);
    key(0);
    out(1, c, 1, 0);
    c = rnd();
    pset(c);
    bus_wr(4'h2, `OMS_HCMD_TO_LINK);
    out(2, c, 1, 0);
    bus_wr(4'h2, `OMS_HCMD_TO_EXT);
    out(0, a, 0, 1);
    conclude();
  end
endmodule

`default_nettype wire
